//--- psbsp_bus_master.sv
// Bus master model holding its side of the shared data and parity lines.
`timescale 1ns/1ps
`default_nettype none
module psbsp_bus_master (
   // Clock.
   input  wire logic        clk_sys_in,
   // Master's own data drive.
   input  wire logic        drive_en_in,
   input  wire logic [35:0] drive_word_in,
   // Port side of the lines.
   input  wire logic [31:0] dq_out_in,
   input  wire logic [3:0]  parity_out_in,
   input  wire logic        port_oe_n_in,
   // Resolved line levels and clash count.
   output logic      [35:0] line_word_out,
   output logic      [7:0]  clash_count_out
);
   logic [35:0] last_r;
   // Starts with quiet lines and no clashes.
   initial begin
      last_r = '0;
      clash_count_out = '0;
   end
   // Resolves the lines; released lines show the inverse level.
   always_comb begin
      if (!port_oe_n_in) line_word_out = {parity_out_in, dq_out_in};
      else if (drive_en_in) line_word_out = drive_word_in;
      else line_word_out = ~last_r;
   end
   // Keeps the last level and counts edges where both sides drive.
   always @(posedge clk_sys_in) begin
      if (!port_oe_n_in || drive_en_in) last_r <= line_word_out;
      if (!port_oe_n_in && drive_en_in)
         clash_count_out <= clash_count_out + 8'h01;
   end
endmodule
`default_nettype wire

//--- psbsp_pkg.sv
// Shared constants, types and state codes for the pipelined burst memory port.
package psbsp_pkg;

   // -------------------------------------------------------------------
   // Geometry of the memory word and the address.
   // -------------------------------------------------------------------
   localparam int LANES   = 4;              // Byte lanes, each with parity.
   localparam int BYTE_W  = 8;              // Data bits in one lane.
   localparam int LANE_W  = BYTE_W + 1;     // Lane with its parity bit.
   localparam int DATA_W  = LANES * BYTE_W;
   localparam int ADDR_W  = 21;             // Word address width.
   localparam int BURST_W = 2;              // Low address bits the burst walks.

   // -------------------------------------------------------------------
   // Buffering and timing.
   // -------------------------------------------------------------------
   localparam int FIFO_DEPTH   = 16;        // Write commit buffer depth.
   localparam int SLEEP_TCYC   = 2;         // Sleep entry or exit, in cycles.
   localparam int SLEEP_CNT_W  = 2;         // Width of the sleep step counter.

   // Burst order pin level that selects interleaved order.
   localparam logic ORDER_INTERLEAVED = 1'h1;

   // Output enable level while the port is not driving.
   localparam logic DRIVE_OFF_N = 1'h1;

   // -------------------------------------------------------------------
   // Types.
   // -------------------------------------------------------------------
   // One captured write on its way to the storage array.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0]  lane_en;
      logic [DATA_W-1:0] data;
      logic [LANES-1:0]  par;
   } psbsp_wr_s;

   localparam int WR_W = $bits(psbsp_wr_s);

   // Sleep sequencing, Gray coded along the entry and exit path.
   typedef enum logic [1:0] {
      PSBSP_AWAKE  = 2'h0,
      PSBSP_ENTER  = 2'h1,
      PSBSP_ASLEEP = 2'h3,
      PSBSP_LEAVE  = 2'h2
   } psbsp_sleep_e;

endpackage

//--- psbsp_port.sv
// Pipelined burst static memory port with its write commit buffer.
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------------------------------
// Write commit FIFO with valid and ready on both sides.
// -------------------------------------------------------------------------
module psbsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input  wire logic             clk_sys_in,
   input  wire logic             rstn_in,
   // Filling side.
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // Draining side.
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int PTR_W = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("psbsp_fifo depth must be a power of two of at least two");
   end

   logic [WIDTH-1:0] store [DEPTH];
   logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt;
   logic [PTR_W-1:0] rd_ptr_r, rd_ptr_nxt;
   logic [PTR_W:0]   count_r, count_nxt;
   logic             push;
   logic             pop;

   // Honest full and empty come straight from the occupancy count.
   assign in_ready_out  = (count_r != (PTR_W+1)'(DEPTH));
   assign out_valid_out = (count_r != '0);
   assign out_data_out  = store[rd_ptr_r];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   // Pointer and count next values.
   always_comb begin
      wr_ptr_nxt = push ? PTR_W'(wr_ptr_r + 1'b1) : wr_ptr_r;
      rd_ptr_nxt = pop ? PTR_W'(rd_ptr_r + 1'b1) : rd_ptr_r;
      count_nxt  = count_r;
      if (push && !pop) begin
         count_nxt = (PTR_W+1)'(count_r + 1'b1);
      end else if (pop && !push) begin
         count_nxt = (PTR_W+1)'(count_r - 1'b1);
      end
   end

   // Pointer and count registers.
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r  <= count_nxt;
      end
   end

   // Entry storage.
   always_ff @(posedge clk_sys_in) begin
      if (push) begin
         store[wr_ptr_r] <= in_data_in;
      end
   end
endmodule

// -------------------------------------------------------------------------
// Memory port top level.
// -------------------------------------------------------------------------
// How it works
// - Qualifier high: edge ignored by the pipeline, state held except drive enable, sleep sequencing and buffer drain.
// - Inputs and read data pass edge registers.
// - Qualifier low, load strobe low: address latched.
// - Selected, write strobe high, load: read starts.
// - Read data driven one edge after command.
// - New command accepted right after a read.
// - Deselect tristates outputs after next edge.
// - Burst counter gives four accesses per address.
// - Order pin: low linear, high interleaved.
// - Counter uses two low bits, wraps.
// - Advance ignores selects and write strobe.
// - Direction latched at burst start only.
// - Selected with write strobe low: write starts.
// - Edge after write: lines tristate always.
// - Write data captured second edge after command.
// - Only enabled lanes with parity updated.
// - Sleep request keeps data, idles device.
// - Interleaved: start xor count.
// - Linear: start plus count modulo four.
// - Sleep entry and exit take two cycles.
// - Reset leaves port deselected, lines tristated.
module psbsp_port #(
   parameter int FIFO_DEPTH = psbsp_pkg::FIFO_DEPTH
) (
   // Clock and reset.
   input  wire logic                           clk_sys_in,
   input  wire logic                           rstn_in,
   // Command inputs from the bus master.
   input  wire logic                           clock_qualifier_n_in,
   input  wire logic                           chip_select_1_n_in,
   input  wire logic                           chip_select_2_in,
   input  wire logic                           chip_select_3_n_in,
   input  wire logic                           advance_or_load_in,
   input  wire logic                           write_n_in,
   input  wire logic [psbsp_pkg::LANES-1:0]    byte_lane_write_n_in,
   input  wire logic [psbsp_pkg::ADDR_W-1:0]   addr_in,
   // Static and slow controls.
   input  wire logic                           output_drive_n_in,
   input  wire logic                           burst_order_in,
   input  wire logic                           sleep_request_in,
   // Shared data and parity lines, split into in, out and enable.
   input  wire logic [psbsp_pkg::DATA_W-1:0]   dq_in,
   input  wire logic [psbsp_pkg::LANES-1:0]    parity_lines_in,
   output logic [psbsp_pkg::DATA_W-1:0]        dq_out,
   output logic [psbsp_pkg::LANES-1:0]         parity_lines_out,
   output logic                                dq_oe_n_out,
   // Status.
   output logic                                asleep_out
);
   localparam int AW    = psbsp_pkg::ADDR_W;
   localparam int LN    = psbsp_pkg::LANES;
   localparam int BW    = psbsp_pkg::BYTE_W;
   localparam int DEPTH = 1 << AW;
   localparam int SCW   = psbsp_pkg::SLEEP_CNT_W;

   if (psbsp_pkg::SLEEP_TCYC < 2 || FIFO_DEPTH < 2) begin : g_chk
      $error("psbsp_port needs sleep steps and fifo depth of two or more");
   end

   // -------------------------------------------------------------------
   // Declarations.
   // -------------------------------------------------------------------
   psbsp_pkg::psbsp_sleep_e  sleep_r, sleep_nxt;
   logic [SCW-1:0]           slp_cnt_r, slp_cnt_nxt;
   logic                     active_r, active_nxt;
   logic                     dir_wr_r, dir_wr_nxt;
   logic [AW-1:0]            base_r, base_nxt;
   logic [1:0]               cnt_r, cnt_nxt;
   logic                     s1_valid_r, s1_valid_nxt;
   logic                     s1_wr_r, s1_wr_nxt;
   logic [AW-1:0]            s1_addr_r, s1_addr_nxt;
   logic [LN-1:0]            s1_lane_r, s1_lane_nxt;
   logic                     s2_valid_r, s2_valid_nxt;
   logic [AW-1:0]            s2_addr_r, s2_addr_nxt;
   logic [LN-1:0]            s2_lane_r, s2_lane_nxt;
   logic                     rd_valid_r, rd_valid_nxt;
   logic [BW*LN-1:0]         dq_r, dq_nxt;
   logic [LN-1:0]            par_r, par_nxt;
   logic                     oe_n_r, oe_n_nxt;
   logic                     asleep_r, asleep_nxt;
   logic                     awake;
   logic                     cs_ok;
   logic                     en;
   logic                     push_ready;
   logic                     push_valid;
   logic                     head_valid;
   logic                     drain;
   psbsp_pkg::psbsp_wr_s     push_ent;
   psbsp_pkg::psbsp_wr_s     head_ent;
   wire logic [BW*LN-1:0]    rd_d;
   wire logic [LN-1:0]       rd_p;

   // Next low address bits of a burst step.
   function automatic logic [1:0] burst_lo(input logic [1:0] start,
                                           input logic [1:0] step,
                                           input logic       order);
      if (order == psbsp_pkg::ORDER_INTERLEAVED) begin
         burst_lo = start ^ step;
      end else begin
         burst_lo = 2'(start + step);
      end
   endfunction

   // -------------------------------------------------------------------
   // Command qualification.
   // -------------------------------------------------------------------
   // A full commit buffer stalls the command pipeline like a held qualifier.
   assign awake = (sleep_r == psbsp_pkg::PSBSP_AWAKE);
   assign cs_ok = ~chip_select_1_n_in & chip_select_2_in & ~chip_select_3_n_in;
   assign en    = ~clock_qualifier_n_in & push_ready;

   // -------------------------------------------------------------------
   // Sleep sequencing.
   // -------------------------------------------------------------------
   // Entry and exit each walk a fixed number of cycles.
   always_comb begin
      sleep_nxt   = sleep_r;
      slp_cnt_nxt = slp_cnt_r;
      unique case (sleep_r)
         psbsp_pkg::PSBSP_AWAKE: begin
            if (sleep_request_in) begin
               sleep_nxt   = psbsp_pkg::PSBSP_ENTER;
               slp_cnt_nxt = SCW'(1);
            end
         end
         psbsp_pkg::PSBSP_ENTER: begin
            if (slp_cnt_r == SCW'(psbsp_pkg::SLEEP_TCYC - 1)) begin
               sleep_nxt = psbsp_pkg::PSBSP_ASLEEP;
            end else begin
               slp_cnt_nxt = SCW'(slp_cnt_r + 1'b1);
            end
         end
         psbsp_pkg::PSBSP_ASLEEP: begin
            if (!sleep_request_in) begin
               sleep_nxt   = psbsp_pkg::PSBSP_LEAVE;
               slp_cnt_nxt = SCW'(1);
            end
         end
         psbsp_pkg::PSBSP_LEAVE: begin
            if (slp_cnt_r == SCW'(psbsp_pkg::SLEEP_TCYC - 1)) begin
               sleep_nxt = psbsp_pkg::PSBSP_AWAKE;
            end else begin
               slp_cnt_nxt = SCW'(slp_cnt_r + 1'b1);
            end
         end
      endcase
      asleep_nxt = (sleep_nxt == psbsp_pkg::PSBSP_ASLEEP);
   end

   // Sleep registers.
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sleep_r   <= psbsp_pkg::PSBSP_AWAKE;
         slp_cnt_r <= '0;
         asleep_r  <= 1'b0;
      end else begin
         sleep_r   <= sleep_nxt;
         slp_cnt_r <= slp_cnt_nxt;
         asleep_r  <= asleep_nxt;
      end
   end

   // -------------------------------------------------------------------
   // Command pipeline and output register.
   // -------------------------------------------------------------------
   // All but the drive enable holds on a qualified-off edge; sleep drops pending work.
   always_comb begin
      active_nxt   = active_r;
      dir_wr_nxt   = dir_wr_r;
      base_nxt     = base_r;
      cnt_nxt      = cnt_r;
      s1_valid_nxt = s1_valid_r;
      s1_wr_nxt    = s1_wr_r;
      s1_addr_nxt  = s1_addr_r;
      s1_lane_nxt  = s1_lane_r;
      s2_valid_nxt = s2_valid_r;
      s2_addr_nxt  = s2_addr_r;
      s2_lane_nxt  = s2_lane_r;
      rd_valid_nxt = rd_valid_r;
      dq_nxt       = dq_r;
      par_nxt      = par_r;
      if (!awake) begin
         active_nxt   = 1'b0;
         s1_valid_nxt = 1'b0;
         s2_valid_nxt = 1'b0;
         rd_valid_nxt = 1'b0;
      end else if (en) begin
         // Second stage holds a write waiting for its data.
         s2_valid_nxt = s1_valid_r & s1_wr_r;
         s2_addr_nxt  = s1_addr_r;
         s2_lane_nxt  = s1_lane_r;
         // Read data moves into the output register one edge on.
         rd_valid_nxt = s1_valid_r & ~s1_wr_r;
         if (s1_valid_r && !s1_wr_r) begin
            dq_nxt  = rd_d;
            par_nxt = rd_p;
         end
         // Decode the command of this edge, whatever came before.
         if (!advance_or_load_in) begin
            if (cs_ok) begin
               active_nxt   = 1'b1;
               dir_wr_nxt   = ~write_n_in;
               base_nxt     = addr_in;
               cnt_nxt      = 2'h0;
               s1_valid_nxt = 1'b1;
               s1_wr_nxt    = ~write_n_in;
               s1_addr_nxt  = addr_in;
               s1_lane_nxt  = ~byte_lane_write_n_in;
            end else begin
               active_nxt   = 1'b0;
               s1_valid_nxt = 1'b0;
            end
         end else if (active_r) begin
            // Advance reads neither selects nor the write strobe.
            cnt_nxt      = 2'(cnt_r + 2'h1);
            s1_valid_nxt = 1'b1;
            s1_wr_nxt    = dir_wr_r;
            s1_addr_nxt  = {base_r[AW-1:2],
                            burst_lo(base_r[1:0], cnt_nxt, burst_order_in)};
            s1_lane_nxt  = ~byte_lane_write_n_in;
         end else begin
            s1_valid_nxt = 1'b0;
         end
      end
      // The drive enable follows read valid gated by the master's enable on every edge.
      oe_n_nxt = ~(rd_valid_nxt & ~output_drive_n_in);
   end

   // Pipeline registers.
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         active_r   <= 1'b0;
         dir_wr_r   <= 1'b0;
         base_r     <= '0;
         cnt_r      <= 2'h0;
         s1_valid_r <= 1'b0;
         s1_wr_r    <= 1'b0;
         s1_addr_r  <= '0;
         s1_lane_r  <= '0;
         s2_valid_r <= 1'b0;
         s2_addr_r  <= '0;
         s2_lane_r  <= '0;
         rd_valid_r <= 1'b0;
         dq_r       <= '0;
         par_r      <= '0;
         oe_n_r     <= psbsp_pkg::DRIVE_OFF_N;
      end else begin
         active_r   <= active_nxt;
         dir_wr_r   <= dir_wr_nxt;
         base_r     <= base_nxt;
         cnt_r      <= cnt_nxt;
         s1_valid_r <= s1_valid_nxt;
         s1_wr_r    <= s1_wr_nxt;
         s1_addr_r  <= s1_addr_nxt;
         s1_lane_r  <= s1_lane_nxt;
         s2_valid_r <= s2_valid_nxt;
         s2_addr_r  <= s2_addr_nxt;
         s2_lane_r  <= s2_lane_nxt;
         rd_valid_r <= rd_valid_nxt;
         dq_r       <= dq_nxt;
         par_r      <= par_nxt;
         oe_n_r     <= oe_n_nxt;
      end
   end

   assign dq_out           = dq_r;
   assign parity_lines_out = par_r;
   assign dq_oe_n_out      = oe_n_r;
   assign asleep_out       = asleep_r;

   // -------------------------------------------------------------------
   // Write capture and commit buffer.
   // -------------------------------------------------------------------
   // The buffer takes the lines on the second edge after the command.
   assign push_valid       = en & awake & s2_valid_r;
   assign push_ent.addr    = s2_addr_r;
   assign push_ent.lane_en = s2_lane_r;
   assign push_ent.data    = dq_in;
   assign push_ent.par     = parity_lines_in;
   // The array is powered down while asleep, which stalls the drain.
   assign drain = head_valid & (sleep_r != psbsp_pkg::PSBSP_ASLEEP);

   psbsp_fifo #(
      .WIDTH (psbsp_pkg::WR_W),
      .DEPTH (FIFO_DEPTH)
   ) u_commit (
      .clk_sys_in    (clk_sys_in),
      .rstn_in       (rstn_in),
      .in_valid_in   (push_valid),
      .in_ready_out  (push_ready),
      .in_data_in    (push_ent),
      .out_valid_out (head_valid),
      .out_ready_in  (drain),
      .out_data_out  (head_ent)
   );

   // -------------------------------------------------------------------
   // Storage array, one slice per lane with its parity bit.
   // -------------------------------------------------------------------
   // A read that meets the write at the buffer head to its word sees the new lanes.
   for (genvar g = 0; g < LN; g++) begin : g_lane
      logic [psbsp_pkg::LANE_W-1:0] lane_mem [DEPTH];
      logic                         fwd;

      always_ff @(posedge clk_sys_in) begin
         if (drain && head_ent.lane_en[g]) begin
            lane_mem[head_ent.addr] <= {head_ent.par[g],
                                        head_ent.data[g*BW +: BW]};
         end
      end

      assign fwd = head_valid & head_ent.lane_en[g] &
                   (head_ent.addr == s1_addr_r);
      assign rd_d[g*BW +: BW] = fwd ? head_ent.data[g*BW +: BW]
                                    : lane_mem[s1_addr_r][BW-1:0];
      assign rd_p[g] = fwd ? head_ent.par[g] : lane_mem[s1_addr_r][BW];
   end

endmodule
`default_nettype wire

//--- psbsp_port_asserts.sv
// Checker of the memory port's timing at its top-level ports.
`timescale 1ns/1ps
`default_nettype none
module psbsp_port_asserts (
   // Clock and reset.
   input wire logic        clk_sys_in,
   input wire logic        rstn_in,
   // Commands and controls.
   input wire logic        clock_qualifier_n_in,
   input wire logic        chip_select_1_n_in,
   input wire logic        chip_select_2_in,
   input wire logic        chip_select_3_n_in,
   input wire logic        advance_or_load_in,
   input wire logic        write_n_in,
   input wire logic        output_drive_n_in,
   input wire logic        sleep_request_in,
   // Outputs under watch.
   input wire logic [31:0] dq_out,
   input wire logic        dq_oe_n_out,
   input wire logic        asleep_out
);
   // -------------------------------------------------------------------
   // Helper logic.
   // -------------------------------------------------------------------
   logic       go, sel, quiet, ld;
   logic [1:0] awake_r, awake_nxt;
   // Enabled edge, full selection and a settled awake port.
   assign go = !clock_qualifier_n_in;
   assign sel = !chip_select_1_n_in && chip_select_2_in && !chip_select_3_n_in;
   assign quiet = awake_r == 2'h3;
   assign ld = quiet && go && !advance_or_load_in;
   // Counts quiet cycles since sleep, saturating at three.
   always_comb begin
      awake_nxt = awake_r;
      if (asleep_out || sleep_request_in) awake_nxt = 2'h0;
      else if (awake_r != 2'h3) awake_nxt = awake_r + 2'h1;
   end
   // Registers the quiet count.
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) awake_r <= 2'h0;
      else awake_r <= awake_nxt;
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   // -------------------------------------------------------------------
   // Assertions.
   // -------------------------------------------------------------------
   stall_hold_a: assert property (quiet && !go |=> $stable(dq_out))
      else $error("read data moved during a stall");
   read_drive_a: assert property ((ld && sel && write_n_in) ##1
      (go && !output_drive_n_in && !sleep_request_in) |=> !dq_oe_n_out)
      else $error("read data not driven one edge after command");
   write_float_a: assert property ((ld && sel && !write_n_in) ##1 go
      |=> dq_oe_n_out)
      else $error("lines driven in the edge after a write");
   deselect_off_a: assert property ((ld && !sel) ##1 go |=> dq_oe_n_out)
      else $error("lines driven after a pipelined deselect");
   drive_off_a: assert property (output_drive_n_in |=> dq_oe_n_out)
      else $error("lines driven without drive permission");
   sleep_enter_a: assert property (quiet && sleep_request_in
      |-> ##[1:2] asleep_out)
      else $error("sleep not entered in two cycles");
   sleep_float_a: assert property (asleep_out |-> dq_oe_n_out)
      else $error("lines driven while asleep");
   reset_idle_a: assert property ($rose(rstn_in)
      |-> dq_oe_n_out && !asleep_out)
      else $error("port not idle after reset");
   // Main scenarios seen.
   cover property (ld && sel && write_n_in);
   cover property (quiet && !go);
   cover property (asleep_out);
endmodule
bind psbsp_port psbsp_port_asserts i_psbsp_port_asserts (.*);
`default_nettype wire

//--- psbsp_port_tb.sv
// Self-checking bench for the pipelined burst memory port.
`timescale 1ns/1ps
`default_nettype none
module psbsp_port_tb;
   logic        clk_sys_in, rstn_in, cq_n, cs_on, adv, wr_n, drv_n;
   logic        order, sleep, m_en, oe_n, asleep;
   logic [3:0]  lanes, par_out;
   logic [20:0] addr;
   logic [35:0] m_word, line;
   logic [31:0] dq_out;
   logic [7:0]  clashes;
   logic [35:0] ref_mem [int];
   int          err_count, samples_checked, cycles;

   psbsp_port i_psbsp_port (
      .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
      .clock_qualifier_n_in(cq_n), .chip_select_1_n_in(!cs_on),
      .chip_select_2_in(cs_on), .chip_select_3_n_in(!cs_on),
      .advance_or_load_in(adv), .write_n_in(wr_n),
      .byte_lane_write_n_in(lanes), .addr_in(addr),
      .output_drive_n_in(drv_n), .burst_order_in(order),
      .sleep_request_in(sleep), .dq_in(line[31:0]),
      .parity_lines_in(line[35:32]), .dq_out(dq_out),
      .parity_lines_out(par_out), .dq_oe_n_out(oe_n), .asleep_out(asleep));
   psbsp_bus_master i_psbsp_bus_master (
      .clk_sys_in(clk_sys_in), .drive_en_in(m_en), .drive_word_in(m_word),
      .dq_out_in(dq_out), .parity_out_in(par_out), .port_oe_n_in(oe_n),
      .line_word_out(line), .clash_count_out(clashes));

   // Makes the 40 MHz clock.
   initial begin
      clk_sys_in = 1'b0;
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end

   // Gives the burst address of beat k in the current order.
   function automatic logic [20:0] baddr(logic [20:0] a, int k);
      return {a[20:2], order ? a[1:0] ^ 2'(k) : 2'(a[1:0] + k)};
   endfunction

   // Makes a distinct word for an address and seed.
   function automatic logic [35:0] pat(logic [20:0] a, logic [7:0] s);
      return {s[3:0] ^ a[3:0], a[15:0], s, a[7:0] ^ 8'h5A};
   endfunction

   // Compares one value and reports a mismatch.
   task automatic check(string what, logic [35:0] seen, logic [35:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   // Presents one command and lets one edge pass.
   task automatic step(logic a, logic w, logic s, logic [20:0] ad,
                       logic [3:0] ln);
      adv = a;
      wr_n = w;
      cs_on = s;
      addr = ad;
      lanes = ln;
      @(posedge clk_sys_in);
      #2;
   endtask

   // Deselects the port for n edges.
   task automatic idle(int n);
      repeat (n) step(1'b0, 1'b1, 1'b0, 21'h0, 4'hF);
   endtask

   // Writes an n-beat burst; data trails by two edges.
   task automatic wr_burst(logic [20:0] a, int n, logic [3:0] ln,
                           logic [7:0] s);
      logic [35:0] old, nw;
      for (int k = 0; k < n; k++) begin
         nw = pat(baddr(a, k), s + 8'(k));
         old = ref_mem.exists(baddr(a, k)) ? ref_mem[baddr(a, k)] : 'x;
         for (int g = 0; g < 4; g++) begin
            if (!ln[g]) old[8*g +: 8] = nw[8*g +: 8];
            if (!ln[g]) old[32+g] = nw[32+g];
         end
         ref_mem[baddr(a, k)] = old;
      end
      for (int i = 0; i < n + 2; i++) begin
         m_en = i >= 2;
         m_word = pat(baddr(a, i - 2), s + 8'(i - 2));
         if (i == 0) step(1'b0, 1'b0, 1'b1, a, ln);
         else if (i < n) step(1'b1, 1'b1, 1'b0, a, ln);
         else step(1'b0, 1'b1, 1'b0, a, 4'hF);
      end
      m_en = 1'b0;
   endtask

   // Reads an n-beat burst, checking data and drive.
   task automatic rd_burst(logic [20:0] a, int n, logic d);
      drv_n = d;
      for (int i = 0; i <= n; i++) begin
         if (i == 0) step(1'b0, 1'b1, 1'b1, a, 4'hF);
         else if (i < n) step(1'b1, 1'b0, 1'b0, a, 4'h0);
         else idle(1);
         if (i > 0) check("drive", oe_n, d);
         if (i > 0 && !d)
            check("data", {par_out, dq_out}, ref_mem[baddr(a, i-1)]);
      end
      idle(1);
      check("release", oe_n, 1'b1);
      drv_n = 1'b0;
   endtask

   // Bursts written in one order, read in the other.
   task automatic t_order();
      wr_burst(21'h101, 5, 4'h0, 8'h10);
      order = 1'b1;
      rd_burst(21'h101, 4, 1'b0);
      wr_burst(21'h206, 4, 4'h0, 8'h20);
      order = 1'b0;
      rd_burst(21'h206, 4, 1'b0);
   endtask

   // Lane writes, read with and without drive.
   task automatic t_lanes();
      wr_burst(21'h300, 1, 4'h0, 8'h30);
      wr_burst(21'h300, 2, 4'hA, 8'h40);
      rd_burst(21'h300, 1, 1'b1);
      rd_burst(21'h300, 1, 1'b0);
   endtask

   // Read, write and read on consecutive edges.
   task automatic t_b2b();
      step(1'b0, 1'b1, 1'b1, 21'h101, 4'hF);
      step(1'b0, 1'b0, 1'b1, 21'h400, 4'h0);
      check("data", {par_out, dq_out}, ref_mem[21'h101]);
      step(1'b0, 1'b1, 1'b1, 21'h206, 4'hF);
      check("write turn", oe_n, 1'b1);
      m_word = pat(21'h400, 8'h50);
      m_en = 1'b1;
      idle(1);
      m_en = 1'b0;
      check("data", {par_out, dq_out}, ref_mem[21'h206]);
      ref_mem[21'h400] = m_word;
      idle(1);
      rd_burst(21'h400, 1, 1'b0);
   endtask

   // A held qualifier freezes the port.
   task automatic t_stall();
      step(1'b0, 1'b1, 1'b1, 21'h206, 4'hF);
      step(1'b1, 1'b1, 1'b0, 21'h0, 4'hF);
      cq_n = 1'b1;
      repeat (3) step(1'b0, 1'b0, 1'b1, 21'h500, 4'h0);
      check("stall", {par_out, dq_out}, ref_mem[21'h206]);
      cq_n = 1'b0;
      idle(1);
      check("stall", {par_out, dq_out}, ref_mem[21'h207]);
      idle(1);
      check("release", oe_n, 1'b1);
   endtask

   // Sleep entry and exit keep stored data.
   task automatic t_sleep();
      sleep = 1'b1;
      idle(2);
      check("asleep", asleep, 1'b1);
      check("sleep drive", oe_n, 1'b1);
      sleep = 1'b0;
      idle(4);
      check("asleep", asleep, 1'b0);
      rd_burst(21'h300, 1, 1'b0);
   endtask

   // Prints counts and verdict, then ends the run.
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Cuts a hang short.
   initial begin
      while (cycles < 3000) @(posedge clk_sys_in) cycles++;
      err_count++;
      conclude();
   end

   // Main sequence.
   initial begin
      {rstn_in, cq_n, cs_on, adv, order, sleep, m_en, drv_n} = 8'h00;
      wr_n = 1'b1;
      lanes = 4'hF;
      addr = '0;
      m_word = '0;
      repeat (16) @(posedge clk_sys_in);
      #2;
      check("reset drive", oe_n, 1'b1);
      check("reset sleep", asleep, 1'b0);
      rstn_in = 1'b1;
      idle(4);
      t_order();
      t_lanes();
      t_b2b();
      t_stall();
      t_sleep();
      check("clash", clashes, 8'h00);
      conclude();
   end
endmodule
`default_nettype wire
